// *** core/stop_seq_pkg.sv ***
// stop mode sequencer constants: mode codes, reset values, wake timer figures
// assumes a single 25 MHz system clock domain
package stop_seq_pkg;

  // --------------------------------------------------------------------------
  // modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    stop_none_req = 2'h0,
    stop1_req = 2'h1,
    stop2_req = 2'h2,
    stop3_req = 2'h3
  } stop_req_t;

  // --------------------------------------------------------------------------
  // timing and widths
  // --------------------------------------------------------------------------
  localparam int unsigned clock_hz = 25000000;
  localparam int unsigned wake_src_hz = 1000;
  localparam int unsigned wake_src_div = clock_hz / wake_src_hz;
  localparam int unsigned rate_width = 3;
  localparam logic [2:0] rate_off = 3'h0;
  localparam logic [2:0] rate_reset = 3'h0;
  localparam int unsigned wake_cnt_width = 16;
  localparam int unsigned div_width = 15;
  localparam int unsigned restart_hold_cycles = 4;
  localparam logic [2:0] restart_hold_last = 3'h3;

endpackage

// *** core/wake_tick_source.sv ***
// self-clocked periodic wake source, modelled as a divider of the system clock
// assumes enable drops whenever the source must stand still
`timescale 1ns/1ps
module wake_tick_source #(
  parameter int unsigned div_count = stop_seq_pkg::wake_src_div
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  output logic tick
);

  logic [stop_seq_pkg::div_width-1:0] div_reg;
  localparam logic [stop_seq_pkg::div_width-1:0] div_last =
    stop_seq_pkg::div_width'(div_count - 1);

  always_ff @(posedge clock) begin
    if (!rst_b || !enable) begin
      div_reg <= '0;
    end else if (div_reg == div_last) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || !enable) begin
      tick <= 1'b0;
    end else begin
      tick <= (div_reg == div_last);
    end
  end

endmodule

// *** core/stop_mode_power_sequencer.sv ***
// stop mode sequencer: takes the cpu stop request, gates peripherals, pins,
// clock generator, regulator and wake sources, and runs the restart
// assumes stop_request is a one-cycle pulse and wake inputs are synchronous
//
// Contract
// - any stop mode stops all peripheral clocks, even with debug entry enabled
// - stop3 leaves pins unchanged, held by their own driving logic
// - stop2 latches all pin states before stop is entered
// - stop1 forces every pin to its reset state on entry
// - stop3 keeps RAM and all registers
// - stop2 wake resets registers, RAM kept
// - pin latches stay closed after stop2 until acknowledge written; software restores
// - stop1 wake resets registers, RAM not guaranteed
// - program memory contents kept in every stop mode
// - stop3 clock generator standby, oscillator or reference kept only if enabled
// - stop2 and stop1 turn clock generator fully off
// - timer units halt in stop, reset after stop2 or stop1
// - converter standby in stop, no conversion, reset after stop2 or stop1
// - enabled keyboard pins can wake from stop3
// - keyboard unit disabled in stop1 and stop2, reset after wake
// - periodic timer wakes in stop2 and stop3, disabled in stop1
// - stop2 uses internal 1 kHz source; stop3 external or internal
// - debug enabled removes internal periodic clock in stop
// - async serial units halt in stop, reset after stop2 or stop1
// - spi unit halts in stop, reset after stop2 or stop1
// - two-wire unit halts in stop, reset after stop2 or stop1
// - regulator standby in stop unless low-voltage stop or debug enabled
// - stop1 or stop2 request becomes stop3 when debug or low-voltage stop enabled
// - stop2 wake flag set after stop2 wake, held until acknowledge
// - rate select zero disables periodic wake and its source
// - stop1 or stop2 wake restarts as power-on, cpu fetches reset vector
`timescale 1ns/1ps
module stop_mode_power_sequencer #(
  parameter int unsigned rate_w = stop_seq_pkg::rate_width,
  parameter int unsigned wake_div = stop_seq_pkg::wake_src_div
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic stop_request,
  input wire logic [1:0] stop_mode_select,
  input wire logic debug_entry_enable,
  input wire logic low_voltage_stop_enable,
  input wire logic osc_keep_enable,
  input wire logic ref_keep_enable,
  input wire logic [rate_w-1:0] periodic_rate_select,
  input wire logic periodic_ext_clock_select,
  input wire logic periodic_ext_tick,
  input wire logic keyboard_wake_pending,
  input wire logic irq_wake_b,
  input wire logic reset_wake,
  input wire logic pin_latch_release_ack,
  output logic peripheral_clock_enable,
  output logic pin_latch_hold,
  output logic pin_force_reset,
  output logic register_reset,
  output logic ram_power_enable,
  output logic flash_retain,
  output logic osc_run,
  output logic ref_run,
  output logic regulator_standby,
  output logic timer_pwm_unit_reset,
  output logic analog_digital_converter_standby,
  output logic analog_digital_converter_reset,
  output logic keyboard_interrupt_unit_enable,
  output logic keyboard_interrupt_unit_reset,
  output logic periodic_wakeup_timer_run,
  output logic periodic_source_internal,
  output logic serial_units_reset,
  output logic stop2_wake_flag,
  output logic cpu_take_reset_vector,
  output logic cpu_take_interrupt,
  output logic [1:0] active_stop_mode
);

  // --------------------------------------------------------------------------
  // mode selection
  // --------------------------------------------------------------------------
  typedef enum {st_run, st_stop, st_restart} seq_state_t;

  seq_state_t state_reg;
  stop_seq_pkg::stop_req_t mode_reg;
  stop_seq_pkg::stop_req_t mode_next;
  logic [2:0] hold_reg;
  logic in_stop;
  logic rate_on;
  logic internal_src;
  logic internal_tick;
  logic timer_tick;
  logic periodic_wake;
  logic kbd_wake;
  logic any_wake;
  logic deep_wake;
  logic [stop_seq_pkg::wake_cnt_width-1:0] period_cnt_reg;
  logic [stop_seq_pkg::wake_cnt_width-1:0] period_last;

  function automatic logic [stop_seq_pkg::wake_cnt_width-1:0] rate_period(input logic [rate_w-1:0] rs);
    // ticks of the 1 kHz source per wake: 8, 32, 64, 128, 256, 512, 1024
    logic [stop_seq_pkg::wake_cnt_width-1:0] p;
    p = '0;
    unique case (rs)
      3'h1: p = 16'h0008;
      3'h2: p = 16'h0020;
      3'h3: p = 16'h0040;
      3'h4: p = 16'h0080;
      3'h5: p = 16'h0100;
      3'h6: p = 16'h0200;
      3'h7: p = 16'h0400;
      default: p = 16'h0001;
    endcase
    return p;
  endfunction

  always_comb begin
    mode_next = stop_seq_pkg::stop_req_t'(stop_mode_select);
    if (mode_next == stop_seq_pkg::stop_none_req) begin
      mode_next = stop_seq_pkg::stop3_req;
    end
    if (debug_entry_enable || low_voltage_stop_enable) begin
      mode_next = stop_seq_pkg::stop3_req;
    end
  end

  assign in_stop = (state_reg == st_stop);
  assign rate_on = (periodic_rate_select != stop_seq_pkg::rate_off);
  // internal source never runs in stop1 or with debug active
  assign internal_src = rate_on && !debug_entry_enable &&
    (mode_reg == stop_seq_pkg::stop2_req ||
     (mode_reg == stop_seq_pkg::stop3_req && !periodic_ext_clock_select));

  wake_tick_source #(
    .div_count(wake_div)
  ) u_wake_tick (
    .clock(clock),
    .rst_b(rst_b),
    .enable(in_stop && internal_src),
    .tick(internal_tick)
  );

  // --------------------------------------------------------------------------
  // periodic wake timer
  // --------------------------------------------------------------------------
  assign timer_tick = internal_src ? internal_tick :
    (periodic_ext_tick && mode_reg == stop_seq_pkg::stop3_req && periodic_ext_clock_select);
  assign period_last = rate_period(periodic_rate_select) - 1'b1;

  always_ff @(posedge clock) begin
    if (!rst_b || !in_stop || !rate_on || mode_reg == stop_seq_pkg::stop1_req) begin
      period_cnt_reg <= '0;
    end else if (timer_tick) begin
      period_cnt_reg <= (period_cnt_reg == period_last) ? '0 : period_cnt_reg + 1'b1;
    end
  end

  assign periodic_wake = in_stop && rate_on && timer_tick && (period_cnt_reg == period_last) &&
    (mode_reg != stop_seq_pkg::stop1_req);
  assign kbd_wake = keyboard_wake_pending && mode_reg == stop_seq_pkg::stop3_req;
  assign any_wake = reset_wake || !irq_wake_b || periodic_wake || kbd_wake;
  assign deep_wake = reset_wake || mode_reg != stop_seq_pkg::stop3_req;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= st_run;
    end else begin
      unique case (state_reg)
        st_run: if (stop_request) state_reg <= st_stop;
        st_stop: if (any_wake) state_reg <= deep_wake ? st_restart : st_run;
        st_restart: if (hold_reg == stop_seq_pkg::restart_hold_last) state_reg <= st_run;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_reg <= stop_seq_pkg::stop3_req;
    end else if (state_reg == st_run && stop_request) begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || state_reg != st_restart) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_reg + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // pin latches and wake flag
  // --------------------------------------------------------------------------
  // latches survive the restart; only an acknowledge opens them
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_latch_hold <= 1'b0;
    end else if (state_reg == st_run && stop_request && mode_next == stop_seq_pkg::stop2_req) begin
      pin_latch_hold <= 1'b1;
    end else if (pin_latch_release_ack && state_reg == st_run) begin
      pin_latch_hold <= 1'b0;
    end
  end

  // set wins over an acknowledge in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stop2_wake_flag <= 1'b0;
    end else if (in_stop && any_wake && mode_reg == stop_seq_pkg::stop2_req) begin
      stop2_wake_flag <= 1'b1;
    end else if (pin_latch_release_ack && state_reg == st_run) begin
      stop2_wake_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // power and clock controls
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      peripheral_clock_enable <= 1'b1;
      pin_force_reset <= 1'b0;
      ram_power_enable <= 1'b1;
      flash_retain <= 1'b1;
      osc_run <= 1'b1;
      ref_run <= 1'b1;
      regulator_standby <= 1'b0;
      analog_digital_converter_standby <= 1'b0;
      keyboard_interrupt_unit_enable <= 1'b1;
      periodic_wakeup_timer_run <= 1'b0;
      periodic_source_internal <= 1'b0;
      active_stop_mode <= 2'h0;
    end else begin
      peripheral_clock_enable <= !in_stop;
      pin_force_reset <= in_stop && mode_reg == stop_seq_pkg::stop1_req;
      ram_power_enable <= !(in_stop && mode_reg == stop_seq_pkg::stop1_req);
      flash_retain <= 1'b1;
      osc_run <= !in_stop || (mode_reg == stop_seq_pkg::stop3_req && osc_keep_enable);
      ref_run <= !in_stop || (mode_reg == stop_seq_pkg::stop3_req && ref_keep_enable);
      regulator_standby <= in_stop && !low_voltage_stop_enable && !debug_entry_enable;
      analog_digital_converter_standby <= in_stop;
      keyboard_interrupt_unit_enable <= !in_stop || mode_reg == stop_seq_pkg::stop3_req;
      periodic_wakeup_timer_run <= in_stop && rate_on && mode_reg != stop_seq_pkg::stop1_req;
      periodic_source_internal <= in_stop && internal_src;
      active_stop_mode <= in_stop ? mode_reg : 2'h0;
    end
  end

  // --------------------------------------------------------------------------
  // restart and wake vectors
  // --------------------------------------------------------------------------
  // one reset strobe drives every block that loses state after a deep wake
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      register_reset <= 1'b1;
      timer_pwm_unit_reset <= 1'b1;
      analog_digital_converter_reset <= 1'b1;
      keyboard_interrupt_unit_reset <= 1'b1;
      serial_units_reset <= 1'b1;
    end else begin
      register_reset <= state_reg == st_restart;
      timer_pwm_unit_reset <= state_reg == st_restart;
      analog_digital_converter_reset <= state_reg == st_restart;
      keyboard_interrupt_unit_reset <= state_reg == st_restart;
      serial_units_reset <= state_reg == st_restart;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cpu_take_reset_vector <= 1'b0;
      cpu_take_interrupt <= 1'b0;
    end else begin
      cpu_take_reset_vector <= state_reg == st_restart &&
        hold_reg == stop_seq_pkg::restart_hold_last;
      cpu_take_interrupt <= in_stop && any_wake && !deep_wake;
    end
  end

endmodule

// *** verification/stop_seq_chk.sv ***
// concurrent checks on the stop mode sequencer ports
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module stop_seq_chk #(
  parameter int unsigned rate_w = 3
) (
  input wire logic clock, rst_b, stop_request, debug_entry_enable, low_voltage_stop_enable,
  input wire logic [rate_w-1:0] periodic_rate_select,
  input wire logic keyboard_wake_pending, irq_wake_b, pin_latch_release_ack, peripheral_clock_enable,
  input wire logic pin_force_reset, register_reset, ram_power_enable, flash_retain, osc_run, ref_run,
  input wire logic regulator_standby, timer_pwm_unit_reset, analog_digital_converter_reset,
  input wire logic analog_digital_converter_standby, keyboard_interrupt_unit_reset, serial_units_reset,
  input wire logic keyboard_interrupt_unit_enable, periodic_wakeup_timer_run, periodic_source_internal,
  input wire logic pin_latch_hold, stop2_wake_flag, cpu_take_reset_vector, cpu_take_interrupt,
  input wire logic [1:0] active_stop_mode
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_entry_gates: assert property (
    stop_request && peripheral_clock_enable && !register_reset && active_stop_mode == 2'h0
    |-> ##2 (!peripheral_clock_enable && analog_digital_converter_standby)) else $error("clocks not stopped");
  a_force_stop3: assert property (
    stop_request && peripheral_clock_enable && !register_reset && active_stop_mode == 2'h0
    && (debug_entry_enable || low_voltage_stop_enable) |-> ##2 active_stop_mode == 2'h3) else $error("not stop3");
  a_stop1_off: assert property (
    active_stop_mode == 2'h1 |-> pin_force_reset && !ram_power_enable
    && !keyboard_interrupt_unit_enable && !periodic_wakeup_timer_run) else $error("stop1 state wrong");
  a_stop3_keep: assert property (active_stop_mode == 2'h3
    |-> !pin_force_reset && ram_power_enable && !register_reset) else $error("stop3 state lost");
  a_gen_off: assert property (active_stop_mode inside {2'h1, 2'h2} |-> !osc_run && !ref_run)
    else $error("clock generator running");
  a_flash_kept: assert property (flash_retain) else $error("flash not retained");
  a_reg_standby: assert property (active_stop_mode != 2'h0
    |-> regulator_standby == !(debug_entry_enable || low_voltage_stop_enable)) else $error("regulator wrong");
  a_restart_len: assert property ($rose(register_reset)
    |-> register_reset [*3] ##1 (register_reset && cpu_take_reset_vector) ##1 !register_reset)
    else $error("restart length wrong");
  a_unit_resets: assert property (timer_pwm_unit_reset == register_reset
    && serial_units_reset == register_reset && analog_digital_converter_reset == register_reset
    && keyboard_interrupt_unit_reset == register_reset) else $error("unit reset differs");
  a_latch_ack: assert property ($fell(pin_latch_hold)
    |-> $past(pin_latch_release_ack) || $past(pin_latch_release_ack, 2)) else $error("latch opened early");
  a_flag_src: assert property ($rose(stop2_wake_flag) |-> $past(active_stop_mode) == 2'h2)
    else $error("flag without stop2");
  a_stop3_wake: assert property (active_stop_mode == 2'h3 && !cpu_take_interrupt
    && (!irq_wake_b || keyboard_wake_pending) |=> cpu_take_interrupt) else $error("no stop3 wake");
  a_rate_off: assert property (
    active_stop_mode != 2'h0 && (periodic_rate_select == '0 || debug_entry_enable)
    |-> !periodic_source_internal) else $error("internal source running");
endmodule

bind stop_mode_power_sequencer stop_seq_chk #(.rate_w(rate_w)) chk (.*);

// *** verification/cpu_model.sv ***
// cpu and software model: issues the stop request and the latch acknowledge
// assumes go is a one-cycle pulse from the bench while the sequencer runs
`timescale 1ns/1ps
module cpu_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire logic cpu_take_reset_vector,
  input wire logic stop2_wake_flag,
  output logic stop_request,
  output logic pin_latch_release_ack
);
  logic [2:0] restore_reg;
  // the wait stands for software restoring saved registers from ram first
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stop_request <= 1'b0;
      pin_latch_release_ack <= 1'b0;
      restore_reg <= 3'h0;
    end else begin
      stop_request <= go;
      pin_latch_release_ack <= restore_reg == 3'h1;
      if (cpu_take_reset_vector && stop2_wake_flag) begin
        restore_reg <= 3'h4;
      end else if (restore_reg != 3'h0) begin
        restore_reg <= restore_reg - 3'h1;
      end
    end
  end
endmodule

// *** verification/tb.sv ***
// self-checking bench: random stop entries and wakes through a cpu model
// assumes the checker is bound to the sequencer and wake_div is shortened
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0, rst_b = 1'b0, go = 1'b0, irq_wake_b = 1'b1, reset_wake = 1'b0;
  logic debug_entry_enable = 1'b0, low_voltage_stop_enable = 1'b0, osc_keep_enable = 1'b0, ref_keep_enable = 1'b0;
  logic periodic_ext_clock_select = 1'b0, periodic_ext_tick = 1'b0, keyboard_wake_pending = 1'b0;
  logic [2:0] periodic_rate_select = 3'h0;
  logic [1:0] stop_mode_select = 2'h0, active_stop_mode, m;
  logic stop_request, pin_latch_release_ack, peripheral_clock_enable, pin_latch_hold, pin_force_reset;
  logic register_reset, ram_power_enable, flash_retain, osc_run, ref_run, regulator_standby;
  logic timer_pwm_unit_reset, analog_digital_converter_standby, analog_digital_converter_reset;
  logic keyboard_interrupt_unit_enable, keyboard_interrupt_unit_reset, periodic_wakeup_timer_run;
  logic periodic_source_internal, serial_units_reset, stop2_wake_flag, cpu_take_reset_vector;
  logic cpu_take_interrupt, saw_int, saw_vec, deep, forced;
  logic [15:0] seed = 16'hece9;
  int n_mismatch = 0, n_checks = 0, src;

  stop_mode_power_sequencer #(.wake_div(4)) uut (.*);
  cpu_model cpu (.*);

  initial begin
    forever #20 clock = ~clock;
  end
  // external ticks free-run so a stop3 periodic wake never waits long
  always @(posedge clock) periodic_ext_tick <= ~periodic_ext_tick;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [1:0] exp_mode(input logic [1:0] sel, input logic f);
    return (f || sel == 2'h0) ? 2'h3 : sel;
  endfunction
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence: first pass plain stop2, second a stop1 request forced to stop3
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    #1;
    chk("reset_strobe", 2'h3, {register_reset, serial_units_reset});
    rst_b <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      @(posedge clock);
      stop_mode_select <= (i == 0) ? 2'h2 : (i == 1) ? 2'h1 : seed[1:0];
      debug_entry_enable <= (i == 1) || (i > 1 && seed[4:2] == 3'h0);
      low_voltage_stop_enable <= i > 1 && seed[7:5] == 3'h0;
      osc_keep_enable <= seed[8];
      ref_keep_enable <= seed[9];
      periodic_rate_select <= seed[12:10];
      periodic_ext_clock_select <= seed[13];
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
      forced = debug_entry_enable || low_voltage_stop_enable;
      m = exp_mode(stop_mode_select, forced);
      chk("mode", m, active_stop_mode);
      chk("clocks", 2'h2, {analog_digital_converter_standby, peripheral_clock_enable});
      chk("latch_force", {m == 2'h2, m == 2'h1}, {pin_latch_hold, pin_force_reset});
      chk("ram", {1'b0, m != 2'h1}, {1'b0, ram_power_enable});
      chk("osc_ref", {m == 2'h3 && osc_keep_enable, m == 2'h3 && ref_keep_enable}, {osc_run, ref_run});
      chk("regulator", {1'b0, !forced}, {1'b0, regulator_standby});
      chk("keyboard", {1'b0, m == 2'h3}, {1'b0, keyboard_interrupt_unit_enable});
      chk("periodic", {m != 2'h1 && periodic_rate_select != 3'h0, m != 2'h1 && periodic_rate_select != 3'h0
        && !debug_entry_enable && (m == 2'h2 || !periodic_ext_clock_select)},
        {periodic_wakeup_timer_run, periodic_source_internal});
      src = seed[15:14];
      if (src == 2 && m != 2'h3) src = 0;
      if (src == 3 && (periodic_rate_select == 3'h0 || m == 2'h1
        || (debug_entry_enable && !(m == 2'h3 && periodic_ext_clock_select)))) src = 1;
      deep = (m != 2'h3) || src == 1;
      @(posedge clock);
      irq_wake_b <= src != 0;
      reset_wake <= src == 1;
      keyboard_wake_pending <= src == 2;
      saw_int = 1'b0;
      saw_vec = 1'b0;
      for (int k = 0; k < 9000 && saw_int !== 1'b1 && saw_vec !== 1'b1; k++) begin
        @(posedge clock);
        #1;
        saw_int = cpu_take_interrupt;
        saw_vec = cpu_take_reset_vector;
      end
      if (saw_int !== 1'b1 && saw_vec !== 1'b1) begin
        n_mismatch++;
        $display("CHECK FAILED wake expected pulse seen none");
        results();
      end
      chk("deep", {1'b0, deep}, {1'b0, saw_vec});
      chk("resets", {deep, deep}, {timer_pwm_unit_reset & serial_units_reset, register_reset});
      if (deep) chk("flag_hold", {2{m == 2'h2}}, {stop2_wake_flag, pin_latch_hold});
      @(posedge clock);
      irq_wake_b <= 1'b1;
      reset_wake <= 1'b0;
      keyboard_wake_pending <= 1'b0;
      repeat (8) @(posedge clock);
      #1;
      chk("released", 2'h0, {stop2_wake_flag, pin_latch_hold});
      chk("run", 2'h1, {register_reset, peripheral_clock_enable});
    end
    results();
  end
endmodule
